// ==== csst_timing.sv ====
// Card slot strobe timing: APB configuration, bus clock divider and access sequencer
`include "csst_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1 - Fast slot 1: strobe starts 1*(count+1)+1 bus clocks after address outputs.
// RQ2 - Fast clear: strobe starts 3*(count+1)+1 bus clocks after address outputs.
// RQ3 - I/O accesses: card enable set-up shortened by the address-to-port-width delay.
// RQ4 - Split 16-bit access to 8-bit I/O: second half set-up 2*(count+1).
// RQ5 - Every strobe stays asserted 3*(count+1) bus clocks, fast bit or not.
// RQ6 - Bus clock period is 2*(count+1) processor clocks from a five-bit count.
// RQ7 - Bit 31 fast bit governs I/O, attribute and memory spaces of slot 1.
// RQ8 - Software picks count: width / cycle / 2 / 3, round up, minus one.
// RQ9 - Slot 1 counts: I/O bits 20:16, attribute 25:21, memory 30:26.
// RQ10 - Slot 0 counts: bits 4:0, 9:5, 14:10; fast bit 15.
// RQ11 - Count and fast bit follow target slot and space; address held through strobe.
module csst_timing (
    input  wire logic               pclk,
    input  wire logic               presetn,
    // APB slave
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output logic [31:0]             prdata,
    output logic                    pready,
    output logic                    pslverr,
    // Access request from the processor side
    input  wire logic               req_valid,
    output logic                    req_ready,
    input  wire logic               req_slot,
    input  wire csst_pkg::csst_space_t req_space,
    input  wire logic               req_write,
    input  wire logic               req_wide,
    input  wire logic [25:0]        req_addr,
    output logic                    acc_done,
    // Card pins
    input  wire logic               card_wide_port_n,
    output logic [25:0]             card_addr,
    output logic                    register_space_select_n,
    output logic                    socket_select,
    output logic                    card_enable_n,
    output logic                    memory_write_strobe_n,
    output logic                    memory_read_strobe_n,
    output logic                    io_write_strobe_n,
    output logic                    io_read_strobe_n,
    output logic                    card_bus_clock
);
    import csst_pkg::*;

    // Set-up or width in bus clocks: mult*(count+1) plus an optional extra period
    function automatic logic [7:0] bus_periods(input logic [2:0] mult, input logic [4:0] cnt,
                                               input logic extra);
        bus_periods = 8'(mult) * (8'(cnt) + 8'h01) + 8'(extra);
    endfunction

    logic [31:0]  expansion_timing_config;
    csst_state_t  state;
    logic [5:0]   pre;
    logic [4:0]   cur_count;
    logic [7:0]   remain;
    logic         cur_io;
    logic         cur_split;
    logic         second_half;
    logic         cur_write;
    logic         wide_s1;
    logic         wide_s2;
    logic         wide_s3;
    logic         wide_filt_n;

    // APB decode; the slave always answers in the access phase
    wire        apb_acc   = psel && penable;
    wire        hit_cfg   = (paddr == `CSST_OFS_CONFIG);
    wire        hit_stat  = (paddr == `CSST_OFS_STATUS);
    wire        cfg_wr    = apb_acc && pwrite && hit_cfg;
    wire [31:0] status    = {27'h0000000, wide_filt_n, second_half, cur_split, state};
    assign pready  = 1'b1;
    assign pslverr = apb_acc && !(hit_cfg || hit_stat);
    assign prdata  = !apb_acc || pwrite ? 32'h0000_0000 :
                     hit_cfg  ? expansion_timing_config :
                     hit_stat ? status : 32'h0000_0000;

    // Count and fast bit selection by slot and space
    wire [4:0] s0_io   = expansion_timing_config[`CSST_POS_S0_IO   +: 5];  // [RQ10]
    wire [4:0] s0_attr = expansion_timing_config[`CSST_POS_S0_ATTR +: 5];  // [RQ10]
    wire [4:0] s0_mem  = expansion_timing_config[`CSST_POS_S0_MEM  +: 5];  // [RQ10]
    wire [4:0] s1_io   = expansion_timing_config[`CSST_POS_S1_IO   +: 5];  // [RQ9]
    wire [4:0] s1_attr = expansion_timing_config[`CSST_POS_S1_ATTR +: 5];  // [RQ9]
    wire [4:0] s1_mem  = expansion_timing_config[`CSST_POS_S1_MEM  +: 5];  // [RQ9]
    wire       fast_s0 = expansion_timing_config[`CSST_POS_S0_FAST];       // [RQ10]
    wire       fast_s1 = expansion_timing_config[`CSST_POS_S1_FAST];       // [RQ7]
    wire [4:0] sel_s0  = req_space == CSST_SPACE_IO ? s0_io :
                         req_space == CSST_SPACE_ATTR ? s0_attr : s0_mem;
    wire [4:0] sel_s1  = req_space == CSST_SPACE_IO ? s1_io :
                         req_space == CSST_SPACE_ATTR ? s1_attr : s1_mem;
    wire [4:0] sel_cnt  = req_slot ? sel_s1 : sel_s0;                      // [RQ11]
    wire       sel_fast = req_slot ? fast_s1 : fast_s0;                    // [RQ7] [RQ11]
    wire [2:0] setup_mult = sel_fast ? 3'(`CSST_SETUP_FAST) : 3'(`CSST_SETUP_NORMAL);
    wire [7:0] setup_len  = bus_periods(setup_mult, sel_cnt, 1'b1);        // [RQ1] [RQ2]
    wire [7:0] strobe_len = bus_periods(3'(`CSST_STROBE_WIDTH), cur_count, 1'b0); // [RQ5]
    wire [7:0] split_len  = bus_periods(3'(`CSST_SETUP_SPLIT), cur_count, 1'b0);  // [RQ4]

    // Bus clock: period 2*(count+1) pclk, restarted when an access is taken
    wire [5:0] half_per = 6'(cur_count) + 6'h01;
    wire       bus_tick = (pre == 6'((7'(half_per) << 1) - 7'h01));         // [RQ6]
    wire       accept   = req_valid && (state == CSST_ST_IDLE);
    wire       last     = bus_tick && (remain == 8'h01);
    assign req_ready = (state == CSST_ST_IDLE);

    // Configuration register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expansion_timing_config <= `CSST_CONFIG_RESET;
        end else if (cfg_wr) begin
            expansion_timing_config <= pwdata;
        end
    end

    // Port-width pin: three flops, a change counts once the last two agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wide_s1     <= 1'b1;
            wide_s2     <= 1'b1;
            wide_s3     <= 1'b1;
            wide_filt_n <= 1'b1;
        end else begin
            wide_s1 <= card_wide_port_n;
            wide_s2 <= wide_s1;
            wide_s3 <= wide_s2;
            if (wide_s2 == wide_s3) begin
                wide_filt_n <= wide_s3;
            end
        end
    end

    // Prescaler and bus clock pin; low for the first half of each period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre            <= 6'h00;
            card_bus_clock <= 1'b0;
        end else begin
            pre            <= (accept || bus_tick) ? 6'h00 : pre + 6'h01;
            card_bus_clock <= !accept && !bus_tick && (pre + 6'h01 >= half_per);  // [RQ6]
        end
    end

    // Access sequencer; address pins 25:1 stay put from acceptance until the last strobe ends, bit 0 is set for the second half of a split
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state                   <= CSST_ST_IDLE;
            cur_count               <= 5'h00;
            remain                  <= 8'h00;
            cur_io                  <= 1'b0;
            cur_split               <= 1'b0;
            second_half             <= 1'b0;
            cur_write               <= 1'b0;
            acc_done                <= 1'b0;
            card_addr               <= 26'h0000000;
            register_space_select_n <= 1'b1;
            socket_select           <= 1'b0;
            card_enable_n           <= 1'b1;
            memory_write_strobe_n   <= 1'b1;
            memory_read_strobe_n    <= 1'b1;
            io_write_strobe_n       <= 1'b1;
            io_read_strobe_n        <= 1'b1;
        end else begin
            acc_done <= 1'b0;
            case (state)
                CSST_ST_IDLE: begin
                    if (accept) begin
                        state                   <= CSST_ST_SETUP;
                        cur_count               <= sel_cnt;                   // [RQ11]
                        remain                  <= setup_len;                 // [RQ1] [RQ2]
                        cur_io                  <= (req_space == CSST_SPACE_IO);
                        cur_split               <= req_wide && (req_space == CSST_SPACE_IO);
                        second_half             <= 1'b0;
                        cur_write               <= req_write;
                        card_addr               <= req_addr;                  // [RQ11]
                        register_space_select_n <= (req_space == CSST_SPACE_MEM);
                        socket_select           <= req_slot;
                        // I/O waits one bus clock for the port-width answer first
                        card_enable_n           <= (req_space == CSST_SPACE_IO);  // [RQ3]
                    end
                end
                CSST_ST_SETUP, CSST_ST_SETUP2: begin
                    if (bus_tick) begin
                        remain <= remain - 8'h01;
                    end
                    // Card enable waits one bus clock for the port-width reply window
                    if (bus_tick && cur_io && card_enable_n) begin
                        card_enable_n <= 1'b0;                                // [RQ3]
                    end
                    if (last) begin
                        state                 <= CSST_ST_STROBE;
                        remain                <= strobe_len;                  // [RQ5]
                        memory_write_strobe_n <= !(!cur_io && cur_write);
                        memory_read_strobe_n  <= !(!cur_io && !cur_write);
                        io_write_strobe_n     <= !(cur_io && cur_write);
                        io_read_strobe_n      <= !(cur_io && !cur_write);
                    end
                end
                CSST_ST_STROBE: begin
                    if (bus_tick) begin
                        remain <= remain - 8'h01;
                    end
                    if (last) begin
                        memory_write_strobe_n <= 1'b1;
                        memory_read_strobe_n  <= 1'b1;
                        io_write_strobe_n     <= 1'b1;
                        io_read_strobe_n      <= 1'b1;
                        // Width pin judged here: the filter needs four pclk, more than
                        // one bus clock at the fastest counts
                        if (cur_split && wide_filt_n && !second_half) begin  // [RQ4]
                            // Upper byte of a split access to an 8-bit card
                            state        <= CSST_ST_SETUP2;
                            remain       <= split_len;                        // [RQ4]
                            second_half  <= 1'b1;
                            card_addr[0] <= 1'b1;
                        end else begin
                            state         <= CSST_ST_IDLE;
                            card_enable_n <= 1'b1;
                            acc_done      <= 1'b1;
                        end
                    end
                end
                default: begin
                    state <= CSST_ST_IDLE;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ==== csst_cfg.svh ====
// Offsets, field positions, reset values and timing counts for the card slot strobe timing block
`ifndef CSST_CFG_SVH
`define CSST_CFG_SVH

// APB register byte addresses
`define CSST_OFS_CONFIG     12'h000
`define CSST_OFS_STATUS     12'h004

// Configuration field positions (low bit of each five-bit count, and the one-bit fast flag of each slot)
`define CSST_POS_S0_IO      0
`define CSST_POS_S0_ATTR    5
`define CSST_POS_S0_MEM     10
`define CSST_POS_S0_FAST    15
`define CSST_POS_S1_IO      16
`define CSST_POS_S1_ATTR    21
`define CSST_POS_S1_MEM     26
`define CSST_POS_S1_FAST    31

// Reset value of the configuration register
`define CSST_CONFIG_RESET   32'h0000_0000

// Bus-clock multipliers for set-up and strobe width
`define CSST_SETUP_NORMAL   3
`define CSST_SETUP_FAST     1
`define CSST_SETUP_SPLIT    2
`define CSST_STROBE_WIDTH   3

`endif

// ==== csst_pkg.sv ====
// Types shared by the card slot strobe timing block
package csst_pkg;

    typedef enum logic [1:0] {
        CSST_SPACE_IO   = 2'b00,
        CSST_SPACE_ATTR = 2'b01,
        CSST_SPACE_MEM  = 2'b10
    } csst_space_t;

    typedef enum logic [1:0] {
        CSST_ST_IDLE   = 2'b00,
        CSST_ST_SETUP  = 2'b01,
        CSST_ST_STROBE = 2'b10,
        CSST_ST_SETUP2 = 2'b11
    } csst_state_t;

endpackage

// ==== csst_card.sv ====
// Model of a removable card answering the port-width pin
`timescale 1ns/1ps
`default_nettype none
module csst_card (
    input  wire logic register_space_select_n,
    input  wire logic wide_port,
    output logic      card_wide_port_n
);
    // Pin pulled up while register_space_select_n is high, so the width reply is given only while it is low (I/O and attribute space)
    assign card_wide_port_n = !(wide_port && !register_space_select_n);
endmodule
`default_nettype wire

// ==== csst_timing_asserts.sv ====
// Port-level checks of strobe timing for the card slot block
`timescale 1ns/1ps
`default_nettype none
module csst_timing_asserts (
    input wire logic                  pclk,
    input wire logic                  presetn,
    input wire logic                  psel,
    input wire logic                  penable,
    input wire logic                  pwrite,
    input wire logic [11:0]           paddr,
    input wire logic [31:0]           pwdata,
    input wire logic                  pslverr,
    input wire logic                  req_valid,
    input wire logic                  req_ready,
    input wire logic                  req_slot,
    input wire csst_pkg::csst_space_t req_space,
    input wire logic                  req_write,
    input wire logic [25:0]           card_addr,
    input wire logic                  register_space_select_n,
    input wire logic                  socket_select,
    input wire logic                  card_enable_n,
    input wire logic                  memory_write_strobe_n,
    input wire logic                  memory_read_strobe_n,
    input wire logic                  io_write_strobe_n,
    input wire logic                  io_read_strobe_n,
    input wire logic                  acc_done,
    input wire logic                  card_bus_clock
);
    import csst_pkg::*;
    logic [31:0] cfg;
    logic [4:0]  c;
    logic        fst, io, mem, wr, sk, seen;
    int          cnt, lowc, hc, nf, cc, bb, sb, wb;
    wire         acc = req_valid && req_ready;
    wire         stb = memory_write_strobe_n & memory_read_strobe_n & io_write_strobe_n
                       & io_read_strobe_n;
    wire [4:0]   base = {req_slot, 4'h0} + 5'(req_space) * 5'h5;
    // Expected times in pclk cycles, from the count latched at acceptance
    assign cc = int'(c) + 1;
    assign bb = 2 * cc;
    assign sb = ((fst ? 1 : 3) * cc + 1) * bb;
    assign wb = 3 * cc * bb;
    // Shadow of the configuration word, kept from APB writes only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= 32'h0;
            cnt <= 0;
            lowc <= 0;
            hc <= 0;
            nf <= 0;
            seen <= 1'b0;
        end else begin
            if (psel && penable && pwrite && paddr == 12'h000) cfg <= pwdata;
            cnt <= acc ? 0 : cnt + 1;
            lowc <= stb ? 0 : lowc + 1;
            hc <= (acc || $changed(card_bus_clock)) ? 1 : hc + 1;
            nf <= acc ? 0 : nf + int'($fell(stb));
            seen <= acc ? 1'b0 : (seen || ($changed(card_bus_clock) && !req_ready));
        end
    end
    // Access parameters caught at the accepting edge
    always_ff @(posedge pclk) begin
        if (acc) begin
            c <= cfg[base +: 5];
            fst <= cfg[{req_slot, 4'hf}];
            io <= req_space == CSST_SPACE_IO;
            mem <= req_space == CSST_SPACE_MEM;
            wr <= req_write;
            sk <= req_slot;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence stb_fall_s;
        $fell(stb);
    endsequence
    first_setup_a: assert property (nf == 0 ##0 stb_fall_s |-> cnt == sb)
        else $error("first strobe set-up wrong");
    split_setup_a: assert property (nf == 1 ##0 stb_fall_s |-> cnt == sb + wb + 2 * cc * bb)
        else $error("second half set-up wrong");
    split_addr_a: assert property (nf == 1 ##0 stb_fall_s |-> card_addr[0])
        else $error("second half address bit low");
    strobe_width_a: assert property ($rose(stb) |-> lowc == wb)
        else $error("strobe width wrong");
    done_edge_a: assert property (acc_done |-> $rose(stb))
        else $error("done not with strobe end");
    strobe_kind_a: assert property (!stb |-> {io_read_strobe_n, io_write_strobe_n,
        memory_read_strobe_n, memory_write_strobe_n} == ~(4'b0001 << {io, !wr}))
        else $error("wrong strobe asserted");
    enable_setup_a: assert property ($fell(card_enable_n) |-> cnt == (io ? bb : 0))
        else $error("card enable timing wrong");
    slot_select_a: assert property ($fell(card_enable_n) |-> socket_select == sk
        && register_space_select_n == mem)
        else $error("slot or space select wrong");
    addr_hold_a: assert property (!card_enable_n && !$past(card_enable_n)
        |-> $stable(card_addr[25:1]))
        else $error("address moved during access");
    bus_period_a: assert property ($changed(card_bus_clock) && seen && !req_ready |-> hc == cc)
        else $error("bus clock half period wrong");
    unmapped_err_a: assert property (psel && penable && paddr != 12'h000 && paddr != 12'h004
        |-> pslverr)
        else $error("unmapped access not refused");
endmodule
bind csst_timing csst_timing_asserts chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pslverr, .req_valid, .req_ready, .req_slot, .req_space, .req_write, .card_addr,
    .register_space_select_n, .socket_select, .card_enable_n, .memory_write_strobe_n,
    .memory_read_strobe_n, .io_write_strobe_n, .io_read_strobe_n, .acc_done, .card_bus_clock);
`default_nettype wire

// ==== tb_top.sv ====
// Self-checking bench for the card slot strobe timing block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import csst_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, wide, rs_n, cwp_n;
    logic        req_valid, req_ready, req_slot, req_write, req_wide, acc_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, cfg;
    logic [25:0] req_addr;
    logic [3:0]  s;
    csst_space_t req_space;
    int          fail_count, total_checks, cc, bb, sb, wb, sp;
    int          cnts [6] = '{1, 0, 5, 2, 3, 0};
    csst_timing uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .req_valid, .req_ready, .req_slot, .req_space, .req_write, .req_wide, .req_addr,
        .acc_done, .card_wide_port_n(cwp_n), .card_addr(), .register_space_select_n(rs_n),
        .socket_select(), .card_enable_n(), .memory_write_strobe_n(s[0]),
        .memory_read_strobe_n(s[1]), .io_write_strobe_n(s[2]), .io_read_strobe_n(s[3]),
        .card_bus_clock());
    csst_card card (.register_space_select_n(rs_n), .wide_port(wide), .card_wide_port_n(cwp_n));
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %0h want %0h", $time, what, got, exp);
        end
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // One APB transfer; waits on pready with a bound instead of assuming zero wait states
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
        if (n >= 50) begin
            fail_count++;
            results();
        end
    endtask
    // One card access; times are counted in pclk edges from the accepting edge
    task automatic access(input int sl, spc, input logic w, wd, input int fall, done);
        int k, kf;
        @(posedge pclk);
        {req_valid, req_wide, req_slot, req_write, req_addr} <= {1'b1, wd, sl[0], w, 26'h2aaaaa2};
        req_space <= csst_space_t'(spc[1:0]);
        @(posedge pclk);
        req_valid <= 1'b0;
        kf = 0;
        for (k = 1; k < 3000 && acc_done !== 1'b1; k++) begin
            @(posedge pclk);
            #1;
            if (kf == 0 && s !== 4'hf) kf = k;
        end
        if (acc_done !== 1'b1) begin
            fail_count++;
            results();
        end
        check(kf, fall, "strobe set-up");
        check(k - 1, done, "access length");
    endtask
    initial begin
        {psel, penable, pwrite, paddr, pwdata, req_valid, req_slot, req_write} = '0;
        {req_wide, req_addr, wide, presetn} = {1'b1, 26'h0, 1'b1, 1'b0};
        req_space = CSST_SPACE_IO;
        fail_count = 0;
        total_checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        cnts[2] = (165 + 29) / 30 - 1;
        apb(1'b0, 12'h000, 32'h0);
        check(rd, 32'h0, "config reset");
        apb(1'b0, 12'h008, 32'h0);
        check({31'h0, err}, 32'h1, "unmapped error");
        apb(1'b0, 12'h004, 32'h0);
        check(rd, 32'h10, "status idle");
        for (int f = 0; f < 2; f++) begin
            cfg = {f[0], 15'h0, f[0], 15'h0};
            for (int i = 0; i < 6; i++) cfg |= 32'(cnts[i]) << (16 * (i / 3) + 5 * (i % 3));
            apb(1'b1, 12'h000, cfg);
            apb(1'b0, 12'h000, 32'h0);
            check(rd, cfg, "config readback");
            wide = f[0];
            // Narrow card on the first pass splits the wide slot 0 I/O access only
            for (int i = 0; i < 6; i++) begin
                cc = cnts[i] + 1;
                bb = 2 * cc;
                sb = ((f ? 1 : 3) * cc + 1) * bb;
                wb = 3 * cc * bb;
                sp = (i == 0 && !wide) ? 2 * cc * bb + wb : 0;
                access(i / 3, i % 3, i[0] ^ f[0], i != 3, sb, sb + wb + sp);
            end
        end
        results();
    end
endmodule
`default_nettype wire
